// ### sdm_pkg.sv
// Package with register map, configuration layout, states and timing for the door monitor
package sdm_pkg;

  // Register byte addresses
  localparam logic [4:0] SDM_ADDR_CTRL   = 5'h00;
  localparam logic [4:0] SDM_ADDR_DELAY  = 5'h04;
  localparam logic [4:0] SDM_ADDR_DISC   = 5'h08;
  localparam logic [4:0] SDM_ADDR_STATUS = 5'h0c;
  localparam logic [4:0] SDM_ADDR_DIAG   = 5'h10;

  // Reset values
  localparam logic [31:0] SDM_CTRL_RST  = 32'h0000_0000;
  localparam logic [15:0] SDM_DELAY_RST = 16'h0000;
  localparam logic [15:0] SDM_DISC_RST  = 16'h0000;

  // Control field width and status field positions
  localparam int SDM_CFG_W       = 20;
  localparam int SDM_ST_STATE_LO = 0;
  localparam int SDM_ST_IMM      = 8;
  localparam int SDM_ST_DEL      = 9;
  localparam int SDM_ST_ERR      = 10;

  // Diagnostic word bit positions
  localparam int SDM_DG_DISC  = 0;
  localparam int SDM_DG_FB    = 4;
  localparam int SDM_DG_REARM = 8;

  // AXI responses
  localparam logic [1:0] SDM_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SDM_RESP_SLVERR = 2'h2;

  // Millisecond tick at 50 MHz
  localparam int SDM_CLK_PERIOD_NS = 20;
  localparam int SDM_TICK_NS       = 1000000;
  localparam int SDM_TICK_CYCLES   = SDM_TICK_NS / SDM_CLK_PERIOD_NS;

  // Configuration held in the control register, msb first
  typedef struct packed {
    logic [2:0] pairEn;
    logic       funcTest;
    logic       rearm;
    logic [1:0] fbActive;
    logic       manualRestart;
    logic [1:0] bypMake;
    logic [1:0] bypEn;
    logic [3:0] monMake;
    logic [3:0] monActive;
  } sdm_cfg_t;

  // Field pins of the block
  typedef struct packed {
    logic [3:0] monitorInput;
    logic       bypassInputA;
    logic       bypassInputB;
    logic       restartInput;
    logic       feedbackLoopA;
    logic       feedbackLoopB;
    logic       groupErrorAckInput;
  } sdm_pins_t;

  // Reported state codes
  typedef enum logic [7:0] {
    SDM_RUN   = 8'h01,
    SDM_STOP  = 8'h02,
    SDM_SAFE  = 8'h03,
    SDM_ERROR = 8'h04,
    SDM_RESET = 8'h05,
    SDM_START = 8'h06
  } sdm_state_t;

endpackage : sdm_pkg

// ### sdm_ms_tick.sv
// Millisecond tick generator
`timescale 1ns/1ps
module sdm_ms_tick #(
  parameter int TICK_CYCLES = sdm_pkg::SDM_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // Tick
  output logic      tick
);
  import sdm_pkg::*;

  logic [31:0] cnt_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= 32'h0;
      tick  <= 1'b0;
    end else if (cnt_q >= 32'(TICK_CYCLES - 1)) begin
      cnt_q <= 32'h0;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h1;
      tick  <= 1'b0;
    end
  end

endmodule : sdm_ms_tick

// ### sdm_pair_check.sv
// Discrepancy timer for one input pair
`timescale 1ns/1ps
module sdm_pair_check (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Control
  input  wire logic        enable,
  input  wire logic        tick,
  input  wire logic [15:0] discMs,
  // Pair
  input  wire logic        chanA,
  input  wire logic        chanB,
  // Result
  output logic             discFault
);
  import sdm_pkg::*;

  logic [15:0] ms_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ms_q      <= 16'h0;
      discFault <= 1'b0;
    end else if (!enable || chanA == chanB) begin
      ms_q      <= 16'h0;
      discFault <= 1'b0;
    end else begin
      if (tick && ms_q != 16'hffff) begin
        ms_q <= ms_q + 16'h1;
      end
      discFault <= (ms_q >= discMs);
    end
  end

endmodule : sdm_pair_check

// ### sdm_door_monitor.sv
// Safety door monitor with AXI4-Lite configuration and status
//
// Contract
// - Four monitor inputs, each break or make
// - Immediate output drops at once, delayed later
// - Two bypass inputs suppress monitor evaluation
// - Manual restart needs full low-high-low pulse
// - Restart pulse has no time limit
// - Auto restart ignores restart input entirely
// - Feedback inputs checked on entering start
// - Manual restart: bad feedback gives error
// - Error left only on group acknowledge
// - Auto restart: bad feedback just stays safe
// - Pair discrepancy beyond time gives error
// - Error state: outputs low, error high
// - Rearm option needs pair both zero
// - Function test gates restart edges
// - Bypass pair checked only with nonzero time
// - Outputs safe until active feedback high
// - Eight-bit state code, immediate output low outside run
// - Run enable low forces stop, outputs low
// - Reset state after acknowledged cleared error
// - Sixteen-bit diagnostic word layout
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module sdm_door_monitor #(
  parameter int TICK_CYCLES = sdm_pkg::SDM_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               rst,
  // AXI4-Lite write address
  input  wire logic [4:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [4:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // Field pins
  input  wire sdm_pkg::sdm_pins_t pins,
  input  wire logic               blockRunEnable,
  // Safety outputs
  output logic                    immediateSafeOutput,
  output logic                    delayedSafeOutput,
  output logic                    errorOutput,
  output logic [7:0]              stateCode,
  output logic [15:0]             diagWord
);
  import sdm_pkg::*;

  // Register file
  logic [31:0] ctrl_q;
  logic [15:0] delayMs_q;
  logic [15:0] discMs_q;
  sdm_cfg_t    cfg;

  // Bus handshake state
  logic        awHeld_q;
  logic        wHeld_q;
  logic [4:0]  awAddr_q;
  logic [31:0] wData_q;
  logic [3:0]  wStrb_q;
  logic        doWrite;
  logic [31:0] delayMerged;
  logic [31:0] discMerged;

  // Block state
  sdm_state_t  state_q;
  sdm_state_t  state_d;
  logic        restartPrev_q;
  logic        delOut_q;
  logic [15:0] delayCnt_q;
  logic [3:0]  seen_q;
  logic [2:0]  discDiag_q;
  logic [2:0]  zeroSeen_q;
  logic [1:0]  fbDiag_q;
  logic        fbFault;

  // Input evaluation
  logic        tick;
  logic [3:0]  monReq;
  logic [1:0]  bypRaw;
  logic [1:0]  bypActive;
  logic        safeReq;
  logic [2:0]  pairFault;
  logic [2:0]  pairEnable;
  logic [2:0]  pairZero;
  logic [2:0]  pairA;
  logic [2:0]  pairB;
  logic        fbOk;
  logic        restartRise;
  logic        restartFall;
  logic        testDone;
  logic        errPending;

  assign cfg = sdm_cfg_t'(ctrl_q[SDM_CFG_W-1:0]);

  // Byte-lane merge used for every writable register
  function automatic logic [31:0] sdm_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction : sdm_merge

  assign delayMerged = sdm_merge({16'h0, delayMs_q}, wData_q, wStrb_q);
  assign discMerged  = sdm_merge({16'h0, discMs_q}, wData_q, wStrb_q);

  // Address decode used by the read path
  function automatic logic sdm_mapped(input logic [4:0] addr);
    return addr == SDM_ADDR_CTRL || addr == SDM_ADDR_DELAY || addr == SDM_ADDR_DISC ||
           addr == SDM_ADDR_STATUS || addr == SDM_ADDR_DIAG;
  endfunction : sdm_mapped

  // Write channel: address and data are taken in either order, response follows both
  assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld_q && !s_axi_bvalid;
  assign doWrite       = awHeld_q && wHeld_q && !s_axi_bvalid;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
      awAddr_q <= 5'h00;
      wData_q  <= 32'h0;
      wStrb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= SDM_RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      // Status and diagnostic words are read-only; writes to them are refused
      s_axi_bresp  <= (awAddr_q == SDM_ADDR_CTRL || awAddr_q == SDM_ADDR_DELAY ||
                       awAddr_q == SDM_ADDR_DISC) ? SDM_RESP_OKAY : SDM_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_q    <= SDM_CTRL_RST;
      delayMs_q <= SDM_DELAY_RST;
      discMs_q  <= SDM_DISC_RST;
    end else if (doWrite) begin
      case (awAddr_q)
        SDM_ADDR_CTRL: begin
          ctrl_q <= sdm_merge(ctrl_q, wData_q, wStrb_q) & {{(32-SDM_CFG_W){1'b0}},
                                                           {SDM_CFG_W{1'b1}}};
        end
        SDM_ADDR_DELAY: begin
          delayMs_q <= delayMerged[15:0];
        end
        SDM_ADDR_DISC: begin
          discMs_q <= discMerged[15:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Read channel: one read in flight, data registered
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= SDM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= sdm_mapped(s_axi_araddr) ? SDM_RESP_OKAY : SDM_RESP_SLVERR;
      case (s_axi_araddr)
        SDM_ADDR_CTRL:   s_axi_rdata <= ctrl_q;
        SDM_ADDR_DELAY:  s_axi_rdata <= {16'h0, delayMs_q};
        SDM_ADDR_DISC:   s_axi_rdata <= {16'h0, discMs_q};
        SDM_ADDR_STATUS: s_axi_rdata <= {21'h0, errorOutput, delayedSafeOutput,
                                         immediateSafeOutput, stateCode};
        SDM_ADDR_DIAG:   s_axi_rdata <= {16'h0, diagWord};
        default:         s_axi_rdata <= 32'h0;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Input evaluation
  sdm_ms_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .mclk (mclk),
    .rst  (rst),
    .tick (tick)
  );

  // Break type requests on 0, make type on 1
  assign monReq    = cfg.monActive & ~(pins.monitorInput ^ cfg.monMake);
  // Break type bypasses while 1, make type while 0
  assign bypRaw    = {pins.bypassInputA, pins.bypassInputB};
  assign bypActive = cfg.bypEn & (bypRaw ^ cfg.bypMake);
  assign safeReq   = (|monReq) && !(|bypActive);

  assign pairA      = {pins.bypassInputA, pins.monitorInput[2], pins.monitorInput[0]};
  assign pairB      = {pins.bypassInputB, pins.monitorInput[3], pins.monitorInput[1]};
  // The bypass pair has no meaning without a discrepancy time
  assign pairEnable = cfg.pairEn & {discMs_q != 16'h0, 2'b11};
  assign pairZero   = ~pairA & ~pairB;

  genvar gp;
  generate
    for (gp = 0; gp < 3; gp++) begin : g_pair
      sdm_pair_check u_pair (
        .mclk      (mclk),
        .rst       (rst),
        .enable    (pairEnable[gp]),
        .tick      (tick),
        .discMs    (discMs_q),
        .chanA     (pairA[gp]),
        .chanB     (pairB[gp]),
        .discFault (pairFault[gp])
      );
    end
  endgenerate

  assign fbOk = (!cfg.fbActive[0] || pins.feedbackLoopA) &&
                (!cfg.fbActive[1] || pins.feedbackLoopB);

  // Edges are used only while manual restart is on
  assign restartRise = cfg.manualRestart && pins.restartInput && !restartPrev_q;
  assign restartFall = cfg.manualRestart && !pins.restartInput && restartPrev_q;
  assign testDone    = !cfg.funcTest || &(seen_q | ~cfg.monActive);

  // An error with rearm stays pending until the pair has been low together
  assign errPending = |pairFault ||
                      (cfg.rearm && |(discDiag_q & ~zeroSeen_q));

  // Feedback check when stepping into start
  assign fbFault = (state_q == SDM_SAFE) && (state_d == SDM_START) && !fbOk;

  always_comb begin
    state_d = state_q;
    case (state_q)
      SDM_STOP: begin
        state_d = SDM_SAFE;
      end
      SDM_SAFE: begin
        if (!safeReq) begin
          if (cfg.manualRestart) begin
            // Both edges may be far apart; nothing times the pulse
            if (restartRise && testDone) begin
              state_d = SDM_START;
            end
          end else if (fbOk) begin
            state_d = SDM_RUN;
          end
        end
      end
      SDM_START: begin
        if (safeReq || !fbOk) begin
          state_d = SDM_SAFE;
        end else if (restartFall) begin
          state_d = SDM_RUN;
        end
      end
      SDM_RUN: begin
        if (safeReq || !fbOk) begin
          state_d = SDM_SAFE;
        end
      end
      SDM_ERROR: begin
        if (pins.groupErrorAckInput && !errPending) begin
          state_d = SDM_RESET;
        end
      end
      SDM_RESET: begin
        state_d = SDM_SAFE;
      end
      default: begin
        state_d = SDM_STOP;
      end
    endcase
  end

  // Main state register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= SDM_STOP;
    end else if (!blockRunEnable) begin
      state_q <= SDM_STOP;
    end else if (|pairFault || fbFault) begin
      state_q <= SDM_ERROR;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      restartPrev_q <= 1'b0;
    end else begin
      restartPrev_q <= pins.restartInput;
    end
  end

  // Function test memory, cleared while stopped
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      seen_q <= 4'h0;
    end else if (!blockRunEnable) begin
      seen_q <= 4'h0;
    end else begin
      seen_q <= seen_q | monReq;
    end
  end

  // Diagnostic flags; a new discrepancy fault in the clearing cycle wins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      discDiag_q <= 3'h0;
      fbDiag_q   <= 2'h0;
      zeroSeen_q <= 3'h0;
    end else begin
      if (state_q == SDM_RESET || !blockRunEnable) begin
        discDiag_q <= pairFault;
        fbDiag_q   <= 2'h0;
        zeroSeen_q <= 3'h0;
      end else begin
        discDiag_q <= discDiag_q | pairFault;
        if (fbFault) begin
          fbDiag_q <= fbDiag_q | (cfg.fbActive &
                      ~{pins.feedbackLoopB, pins.feedbackLoopA});
        end
        zeroSeen_q <= (zeroSeen_q | (discDiag_q & pairZero)) & ~pairFault;
      end
    end
  end

  // Delayed output keeps running out its time after a request in run
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      delOut_q   <= 1'b0;
      delayCnt_q <= 16'h0;
    end else if (!blockRunEnable || state_q == SDM_ERROR || |pairFault || fbFault) begin
      delOut_q   <= 1'b0;
      delayCnt_q <= 16'h0;
    end else if (state_d == SDM_RUN && state_q != SDM_RUN) begin
      delOut_q   <= 1'b1;
      delayCnt_q <= 16'h0;
    end else if (state_q == SDM_RUN && state_d == SDM_SAFE) begin
      delOut_q   <= (delayMs_q != 16'h0);
      delayCnt_q <= delayMs_q;
    end else if (state_q != SDM_RUN && delOut_q && tick) begin
      if (delayCnt_q <= 16'h1) begin
        delOut_q   <= 1'b0;
        delayCnt_q <= 16'h0;
      end else begin
        delayCnt_q <= delayCnt_q - 16'h1;
      end
    end
  end

  // Outputs; the immediate output follows the request without waiting a clock
  assign immediateSafeOutput = (state_q == SDM_RUN) && !safeReq && fbOk &&
                               blockRunEnable && !(|pairFault);
  assign delayedSafeOutput   = delOut_q;
  assign errorOutput         = (state_q == SDM_ERROR);
  assign stateCode           = state_q;
  assign diagWord            = {5'h00, cfg.rearm ? discDiag_q : 3'h0, 2'h0, fbDiag_q,
                                1'b0, discDiag_q};

endmodule : sdm_door_monitor

// ### sdm_chk_monitor.sv
// Checker tying the door monitor outputs to their causes
`timescale 1ns/1ps
module sdm_chk_monitor #(
  parameter int TICK_CYCLES = 10
) (
  // Clock and reset
  input wire logic               mclk,
  input wire logic               rst,
  // Field side
  input wire sdm_pkg::sdm_pins_t pins,
  input wire logic               blockRunEnable,
  // Outputs under watch
  input wire logic               immediateSafeOutput,
  input wire logic               delayedSafeOutput,
  input wire logic               errorOutput,
  input wire logic [7:0]         stateCode,
  input wire logic [15:0]        diagWord
);
  import sdm_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence enterStart;
    $rose(stateCode == SDM_START);
  endsequence
  sequence errorUnacked;
    errorOutput && !pins.groupErrorAckInput && blockRunEnable;
  endsequence
  chk_stop_forced: assert property (
    !blockRunEnable && !$past(blockRunEnable) |-> stateCode == SDM_STOP &&
    !immediateSafeOutput && !delayedSafeOutput && !errorOutput)
    else $error("outputs live while run enable low");
  chk_nonrun_safe: assert property (
    stateCode != SDM_RUN |-> !immediateSafeOutput)
    else $error("immediate output high outside run");
  chk_error_outputs: assert property (
    (errorOutput == (stateCode == SDM_ERROR)) && (!errorOutput || !delayedSafeOutput))
    else $error("error output and state disagree");
  chk_error_hold: assert property (
    errorUnacked |=> errorOutput)
    else $error("error left without acknowledge");
  chk_reset_after: assert property (
    $fell(errorOutput) && $past(blockRunEnable) |-> stateCode == SDM_RESET)
    else $error("error not followed by reset state");
  chk_start_entry: assert property (
    enterStart |-> $past(stateCode) == SDM_SAFE && $past(pins.restartInput))
    else $error("start entered without restart rise");
  chk_start_leave: assert property (
    stateCode == SDM_START && !pins.restartInput |=> stateCode != SDM_START)
    else $error("start held after restart fell");
  chk_run_together: assert property (
    $rose(immediateSafeOutput) |-> delayedSafeOutput && stateCode == SDM_RUN)
    else $error("outputs did not re-enable together");
  chk_diag_flag: assert property (
    $rose(errorOutput) |-> ##[0:1] (diagWord[2:0] != 3'h0 || diagWord[5:4] != 2'h0))
    else $error("error without diagnostic flag");
  chk_diag_rearm: assert property (
    (diagWord[10:8] & ~diagWord[2:0]) == 3'h0)
    else $error("rearm flag without discrepancy flag");
endmodule : sdm_chk_monitor

// ### sdm_field_model.sv
// Field side model: door, bypass and restart switches plus contactor feedback
`timescale 1ns/1ps
module sdm_field_model (
  // Switch levels from the bench
  input  wire logic [3:0]     monLevel,
  input  wire logic           bypA,
  input  wire logic           bypB,
  input  wire logic           restartBtn,
  input  wire logic           ackBtn,
  // Contactor faults, a stuck contactor opens its mirror contact
  input  wire logic           stuckA,
  input  wire logic           stuckB,
  // Pins seen by the block
  output sdm_pkg::sdm_pins_t  pins
);
  import sdm_pkg::*;
  assign pins.monitorInput       = monLevel;
  assign pins.bypassInputA       = bypA;
  assign pins.bypassInputB       = bypB;
  assign pins.restartInput       = restartBtn;
  assign pins.groupErrorAckInput = ackBtn;
  // Mirror contacts read 1 while healthy; level feedback keeps the model simple
  assign pins.feedbackLoopA      = !stuckA;
  assign pins.feedbackLoopB      = !stuckB;
endmodule : sdm_field_model

// ### sdm_door_monitor_tb.sv
// Testbench for the safety door monitor
`timescale 1ns/1ps
module sdm_door_monitor_tb;
  import sdm_pkg::*;
  localparam int TICKS = 10;
  logic        mclk, rst, runEn, awvalid, wvalid, arvalid;
  logic        awready, wready, bvalid, arready, rvalid, imm, del, err;
  logic        bypA, bypB, rstBtn, ack, stuckA, stuckB;
  logic [4:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, dat;
  logic [1:0]  bresp, rresp, rsp;
  logic [3:0]  mon;
  logic [7:0]  state;
  logic [15:0] diag;
  sdm_pins_t   pins;
  int          failures, cmp_count;
  sdm_field_model field (.monLevel(mon), .bypA, .bypB, .restartBtn(rstBtn), .ackBtn(ack),
    .stuckA, .stuckB, .pins);
  sdm_door_monitor #(.TICK_CYCLES(TICKS)) uut (.mclk, .rst,
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .pins, .blockRunEnable(runEn), .immediateSafeOutput(imm), .delayedSafeOutput(del),
    .errorOutput(err), .stateCode(state), .diagWord(diag));
  always #10 mclk = ~mclk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  task automatic st(input int n, input logic [7:0] s);
    cyc(n);
    @(negedge mclk);
    chk(state, s);
  endtask : st
  // Handshakes are judged at the falling edge; nothing moves between it and the next rise
  task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, b;
    b = 1'b0;
    @(posedge mclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (!b) begin
      @(negedge mclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      b  = bvalid;
      r  = bresp;
      @(posedge mclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, v;
    v = 1'b0;
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'b1;
    while (!v) begin
      @(negedge mclk);
      ta = arvalid && arready;
      v  = rvalid;
      d  = rdata;
      r  = rresp;
      @(posedge mclk);
      if (ta) arvalid <= 1'b0;
    end
  endtask : rd
  task automatic bump(input logic [3:0] v);
    cyc(1);
    mon <= v;
    cyc(3);
    mon <= 4'hb;
    cyc(3);
  endtask : bump
  task automatic pulse;
    cyc(1);
    rstBtn <= 1'b1;
    cyc(4);
    rstBtn <= 1'b0;
    cyc(4);
  endtask : pulse
  task automatic close_out;
    if (failures == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out
  initial begin
    cyc(6000);
    failures++;
    close_out;
  end
  initial begin
    {mclk, runEn, awvalid, wvalid, arvalid, bypA, bypB, rstBtn, ack, stuckA, stuckB} = '0;
    {awaddr, araddr, wdata} = '0;
    rst = 1'b1;
    mon = 4'hf;
    failures = 0;
    cmp_count = 0;
    st(4, SDM_STOP);
    chk({imm, del, err}, 3'h0);
    cyc(1);
    rst <= 1'b0;
    rd(SDM_ADDR_CTRL, dat, rsp);
    chk(dat, SDM_CTRL_RST);
    rd(SDM_ADDR_DELAY, dat, rsp);
    chk(dat, {16'h0, SDM_DELAY_RST});
    rd(5'h14, dat, rsp);
    chk(dat, 32'h0);
    chk(rsp, SDM_RESP_SLVERR);
    wr(SDM_ADDR_STATUS, 32'h1, rsp);
    chk(rsp, SDM_RESP_SLVERR);
    runEn <= 1'b1;
    st(4, SDM_RUN);
    chk({imm, del, err}, 3'h6);
    wr(SDM_ADDR_DELAY, 32'h2, rsp);
    // Inputs 0..2 active, input 2 make type, bypass A break type
    wr(SDM_ADDR_CTRL, 32'h0000_0247, rsp);
    st(3, SDM_SAFE);
    cyc(1);
    mon <= 4'hb;
    st(4, SDM_RUN);
    cyc(1);
    mon <= 4'ha;
    @(negedge mclk);
    chk(imm, 1'b0);
    st(5, SDM_SAFE);
    chk(del, 1'b1);
    st(40, SDM_SAFE);
    chk(del, 1'b0);
    cyc(1);
    mon <= 4'hb;
    st(3, SDM_RUN);
    chk({imm, del}, 2'h3);
    cyc(1);
    bypA <= 1'b1;
    mon <= 4'h4;
    st(5, SDM_RUN);
    cyc(1);
    bypA <= 1'b0;
    st(3, SDM_SAFE);
    cyc(1);
    mon <= 4'hb;
    wr(SDM_ADDR_CTRL, 32'h0000_3247, rsp);
    bump(4'ha);
    st(5, SDM_SAFE);
    cyc(1);
    rstBtn <= 1'b1;
    st(3, SDM_START);
    st(60, SDM_START);
    cyc(1);
    rstBtn <= 1'b0;
    st(3, SDM_RUN);
    bump(4'ha);
    stuckA <= 1'b1;
    rstBtn <= 1'b1;
    st(4, SDM_ERROR);
    chk({imm, del, err}, 3'h1);
    rd(SDM_ADDR_DIAG, dat, rsp);
    chk(dat, 32'h0000_0010);
    rstBtn <= 1'b0;
    stuckA <= 1'b0;
    st(10, SDM_ERROR);
    cyc(1);
    ack <= 1'b1;
    st(1, SDM_RESET);
    cyc(1);
    ack <= 1'b0;
    st(3, SDM_SAFE);
    pulse;
    st(0, SDM_RUN);
    wr(SDM_ADDR_CTRL, 32'h0000_2247, rsp);
    stuckA <= 1'b1;
    st(4, SDM_SAFE);
    chk(err, 1'b0);
    cyc(1);
    stuckA <= 1'b0;
    st(3, SDM_RUN);
    // Pair 0 with rearm; short disagreements must not add up
    wr(SDM_ADDR_DISC, 32'h2, rsp);
    wr(SDM_ADDR_CTRL, 32'h0002_8003, rsp);
    // Enough short disagreements that several ticks land inside them
    repeat (7) bump(4'h9);
    @(negedge mclk);
    chk(err, 1'b0);
    cyc(1);
    mon <= 4'ha;
    st(50, SDM_ERROR);
    rd(SDM_ADDR_DIAG, dat, rsp);
    chk(dat, 32'h0000_0101);
    ack <= 1'b1;
    st(5, SDM_ERROR);
    cyc(1);
    mon <= 4'h8;
    st(4, SDM_SAFE);
    cyc(1);
    ack <= 1'b0;
    mon <= 4'hb;
    st(3, SDM_RUN);
    cyc(1);
    runEn <= 1'b0;
    st(2, SDM_STOP);
    chk({imm, del, err}, 3'h0);
    cyc(1);
    rst <= 1'b1;
    cyc(3);
    rst <= 1'b0;
    wr(SDM_ADDR_CTRL, 32'h0001_1003, rsp);
    runEn <= 1'b1;
    st(3, SDM_SAFE);
    pulse;
    st(0, SDM_SAFE);
    bump(4'h8);
    pulse;
    st(0, SDM_RUN);
    // Bypass pair disagrees; only a nonzero discrepancy time arms its check
    wr(SDM_ADDR_CTRL, 32'h0008_0003, rsp);
    bypA <= 1'b1;
    st(40, SDM_RUN);
    wr(SDM_ADDR_DISC, 32'h2, rsp);
    st(40, SDM_ERROR);
    close_out;
  end
endmodule : sdm_door_monitor_tb
bind sdm_door_monitor sdm_chk_monitor #(.TICK_CYCLES(TICK_CYCLES)) chk_i (.mclk, .rst, .pins,
  .blockRunEnable, .immediateSafeOutput, .delayedSafeOutput, .errorOutput, .stateCode,
  .diagWord);
